/* logic/clkgen_pkg.sv */
// Constants shared by the clock output control logic
package clkgen_pkg;
    // Serial-bus addresses selected by the address strap
    localparam logic [6:0] BUS_ADDR_STRAP_LOW = 7'h68;
    localparam logic [6:0] BUS_ADDR_STRAP_HIGH = 7'h6A;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // Control register field positions
    localparam int PAIR_EN_LSB = 0;
    localparam int REF_ENABLE_BIT = 8;
    localparam int REF_RUN_PD_BIT = 9;
    localparam int PARK_LSB = 16;

    // Control register reset values
    localparam logic [5:0] PAIR_EN_RESET = 6'h3F;
    localparam logic REF_ENABLE_RESET = 1'b1;
    localparam logic REF_RUN_PD_RESET = 1'b0;
    localparam logic [1:0] PARK_RESET = 2'h0;

    // Status register field positions
    localparam int STAT_ADDR_LSB = 0;
    localparam int STAT_SPREAD_LSB = 8;
    localparam int STAT_LOCK_BIT = 12;
    localparam int STAT_STARTED_BIT = 13;
    localparam int STAT_PD_BIT = 14;
    localparam int STAT_RUN_LSB = 16;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Three-level strap as seen by the pin receiver
    typedef enum logic [1:0] {
        STRAP_LOW,
        STRAP_MID,
        STRAP_HIGH
    } strap_level_t;

    // Spread amount applied to the PLL
    typedef enum logic [1:0] {
        SPREAD_OFF,
        SPREAD_QUARTER,
        SPREAD_HALF
    } spread_sel_t;
endpackage

/* logic/clock_output_power_gating.sv */
// Output gating, strap capture and register access of the clock generator
`timescale 1ns/10ps
`default_nettype none
module clock_output_power_gating
    import clkgen_pkg::*;
#(
    parameter int PAIRS = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic power_good_power_down_n,
    input wire logic pll_lock,
    input wire logic ref_clk_in,
    input wire logic bus_address_strap_in,
    output logic bus_address_strap_out,
    output logic bus_address_strap_oe,
    input wire logic [1:0] spread_strap_level,
    input wire logic [PAIRS-1:0] pair_enable_n,
    output logic [PAIRS-1:0] diff_clock_pair_true,
    output logic [PAIRS-1:0] diff_clock_pair_comp,
    output logic [6:0] bus_address,
    output logic [1:0] spread_select,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic started_q;
    logic addr_strap_q;
    spread_sel_t spread_q;
    logic [PAIRS-1:0] pair_en_q;
    logic ref_enable_q;
    logic ref_run_pd_q;
    logic [1:0] park_q;
    logic phase_q;
    logic [PAIRS-1:0] gate_q;
    logic [PAIRS-1:0] true_q;
    logic [PAIRS-1:0] comp_q;
    logic ref_out_q;
    logic ref_oe_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wire first_pg = power_good_power_down_n && !started_q;
    // Power-good low after start-up is power-down, not a reset
    wire powered_down = started_q && !power_good_power_down_n;
    wire outputs_live = started_q && power_good_power_down_n && pll_lock;
    wire [PAIRS-1:0] pair_run = {PAIRS{outputs_live}} & pair_en_q
        & ~pair_enable_n;
    wire ref_running = started_q && ref_enable_q
        && (power_good_power_down_n || ref_run_pd_q);
    spread_sel_t spread_d;
    assign spread_d = (spread_strap_level == STRAP_HIGH) ? SPREAD_HALF :
        (spread_strap_level == STRAP_MID) ? SPREAD_QUARTER :
        SPREAD_OFF;

    // Strap capture happens on a clock edge, never under reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            started_q <= 1'b0;
            addr_strap_q <= 1'b0;
            spread_q <= SPREAD_OFF;
        end else if (first_pg) begin
            started_q <= 1'b1;
            addr_strap_q <= bus_address_strap_in;
            spread_q <= spread_d;
        end
    end

    assign bus_address = addr_strap_q ? BUS_ADDR_STRAP_HIGH
        : BUS_ADDR_STRAP_LOW;
    assign spread_select = spread_q;

    // Gates follow their request only at the end of a full period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= 1'b0;
            gate_q <= '0;
        end else begin
            phase_q <= !phase_q;
            if (phase_q) begin
                gate_q <= pair_run;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            true_q <= '0;
            comp_q <= '0;
        end else begin
            for (int i = 0; i < PAIRS; i++) begin
                true_q[i] <= gate_q[i] ? phase_q : park_q[1];
                comp_q[i] <= gate_q[i] ? !phase_q : park_q[0];
            end
        end
    end
    assign diff_clock_pair_true = true_q;
    assign diff_clock_pair_comp = comp_q;

    // Pin stays an input until the strap has been read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_out_q <= 1'b0;
            ref_oe_q <= 1'b0;
        end else begin
            ref_oe_q <= started_q;
            ref_out_q <= ref_running && ref_clk_in;
        end
    end
    assign bus_address_strap_out = ref_out_q;
    assign bus_address_strap_oe = ref_oe_q;

    // Register slave: write address and data are taken together
    wire wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    wire wr_ctrl = wr_take && (s_axi_awaddr == CTRL_OFFSET);
    wire wr_ok = wr_ctrl || (s_axi_awaddr == STATUS_OFFSET);
    wire rd_take = s_axi_arvalid && !rvalid_q;
    wire [31:0] ctrl_word = {14'h0000, park_q, 6'h00, ref_run_pd_q,
        ref_enable_q, 2'h0, pair_en_q};
    wire [31:0] status_word = {10'h000, pair_run, 1'b0, powered_down,
        started_q, pll_lock, 2'h0, spread_q, 1'b0, bus_address};
    wire rd_ctrl = s_axi_araddr == CTRL_OFFSET;
    wire rd_stat = s_axi_araddr == STATUS_OFFSET;
    wire [31:0] rd_word = rd_ctrl ? ctrl_word :
        rd_stat ? status_word : 32'h0000_0000;

    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign s_axi_arready = rd_take;

    // Defaults run every output with no bus traffic at all
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pair_en_q <= PAIR_EN_RESET;
            ref_enable_q <= REF_ENABLE_RESET;
            ref_run_pd_q <= REF_RUN_PD_RESET;
            park_q <= PARK_RESET;
        end else if (wr_ctrl) begin
            if (s_axi_wstrb[0]) begin
                pair_en_q <= s_axi_wdata[PAIR_EN_LSB +: PAIRS];
            end
            if (s_axi_wstrb[1]) begin
                ref_enable_q <= s_axi_wdata[REF_ENABLE_BIT];
                ref_run_pd_q <= s_axi_wdata[REF_RUN_PD_BIT];
            end
            if (s_axi_wstrb[2]) begin
                park_q <= s_axi_wdata[PARK_LSB +: 2];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            if (wr_take) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (rd_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_addr_latch;
        $rose(started_q) |-> bus_address == ($past(bus_address_strap_in)
            ? BUS_ADDR_STRAP_HIGH : BUS_ADDR_STRAP_LOW);
    endproperty
    a_addr_latch: assert property (p_addr_latch)
        else $error("bus address does not match latched strap");

    property p_ref_copy;
        started_q && power_good_power_down_n && ref_enable_q
            |=> ref_oe_q && ref_out_q == $past(ref_clk_in);
    endproperty
    a_ref_copy: assert property (p_ref_copy)
        else $error("strap pin does not carry reference copy");

    property p_spread_latch;
        $rose(started_q) |-> spread_q == ($past(spread_strap_level)
            == STRAP_HIGH ? SPREAD_HALF : $past(spread_strap_level)
            == STRAP_MID ? SPREAD_QUARTER : SPREAD_OFF);
    endproperty
    a_spread_latch: assert property (p_spread_latch)
        else $error("spread selection does not match strap");

    property p_pin_disable;
        (pair_enable_n[0] && $stable(park_q)) [*4]
            |-> true_q[0] == park_q[1] && comp_q[0] == park_q[0];
    endproperty
    a_pin_disable: assert property (p_pin_disable)
        else $error("pair not parked after enable pin high");

    property p_park_before_start;
        !started_q && $stable(park_q) |-> true_q == {PAIRS{park_q[1]}}
            && comp_q == {PAIRS{park_q[0]}};
    endproperty
    a_park_before_start: assert property (p_park_before_start)
        else $error("pair toggles before start-up");

    property p_ref_float;
        !started_q |=> !ref_oe_q;
    endproperty
    a_ref_float: assert property (p_ref_float)
        else $error("reference output driven before power-good");

    property p_ref_pd;
        powered_down && !ref_run_pd_q |=> ref_oe_q && !ref_out_q;
    endproperty
    a_ref_pd: assert property (p_ref_pd)
        else $error("reference output runs in power-down");

    property p_lock_block;
        (!pll_lock && $stable(park_q)) [*4]
            |-> true_q == {PAIRS{park_q[1]}};
    endproperty
    a_lock_block: assert property (p_lock_block)
        else $error("pair runs without PLL lock");

    property p_pd_park;
        (powered_down && $stable(park_q)) [*4]
            |-> comp_q == {PAIRS{park_q[0]}};
    endproperty
    a_pd_park: assert property (p_pd_park)
        else $error("pair runs in power-down");

    property p_ref_bit;
        started_q && !ref_enable_q |=> !ref_out_q;
    endproperty
    a_ref_bit: assert property (p_ref_bit)
        else $error("reference runs with its enable bit clear");

    property p_gate_boundary;
        gate_q != $past(gate_q) |-> !phase_q;
    endproperty
    a_gate_boundary: assert property (p_gate_boundary)
        else $error("pair gate changed mid-period");

    c_start: cover property ($rose(started_q));
    c_pair_runs: cover property (gate_q[0] [*4]);
    c_pd_exit: cover property (powered_down ##[1:50] !powered_down);
    c_write: cover property (wr_ctrl);
endmodule
`default_nettype wire

/* verif/board_model.sv */
// Board side: reference oscillator and the strap resistor on the shared pin
`timescale 1ns/10ps
`default_nettype none
module board_model (
    input wire logic clk,
    input wire logic strap_val,
    input wire logic strap_oe,
    input wire logic strap_drv,
    output logic ref_clk,
    output logic strap_pin
);
    logic [1:0] div_q = 2'h0;
    initial ref_clk = 1'b0;
    // Odd divide so a copy that lags by one cycle is visible
    always @(posedge clk) begin
        div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
        if (div_q == 2'h2) begin
            ref_clk <= ~ref_clk;
        end
    end
    // Strap resistor sets the level until the device drives the pin
    assign strap_pin = strap_oe ? strap_drv : strap_val;
endmodule
`default_nettype wire

/* verif/tb_clock_output_power_gating.sv */
// Bench for the clock output gating block
`timescale 1ns/10ps
`default_nettype none
module tb_clock_output_power_gating;
    import clkgen_pkg::*;
    logic clk, rst, pg, lock, ref_in, s_in, s_out, s_oe, s_val;
    logic [1:0] sp_sel, sp_lvl;
    logic [5:0] en_n, t, c;
    logic [6:0] b_addr;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic awvalid, awready, wready, wvalid, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ref_prev;
    int n_fail, check_count;
    clock_output_power_gating #(.PAIRS(6)) dut (.clk(clk), .rst(rst),
        .power_good_power_down_n(pg), .pll_lock(lock), .ref_clk_in(ref_in),
        .bus_address_strap_in(s_in), .bus_address_strap_out(s_out),
        .bus_address_strap_oe(s_oe), .spread_strap_level(sp_lvl),
        .pair_enable_n(en_n), .diff_clock_pair_true(t),
        .diff_clock_pair_comp(c), .bus_address(b_addr),
        .spread_select(sp_sel), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    board_model board (.clk(clk), .strap_val(s_val), .strap_oe(s_oe),
        .strap_drv(s_out), .ref_clk(ref_in), .strap_pin(s_in));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) ref_prev <= ref_in;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d of %0d checks", n_fail, check_count);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge clk); while (!(awready && wready));
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge clk); while (!bvalid);
        rs = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        rd = rdata;
        rs = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    // Parked pairs must hold the programmed levels over two cycles
    task automatic park_chk(input logic [5:0] m, input logic [1:0] p);
        repeat (2) begin
            @(negedge clk);
            for (int i = 0; i < 6; i++) begin
                if (m[i]) begin
                    chk(t[i], p[1]);
                    chk(c[i], p[0]);
                end
            end
        end
    endtask
    task automatic run_chk(input int i);
        logic v;
        @(negedge clk);
        v = t[i];
        chk(c[i], !v);
        @(negedge clk);
        chk(t[i], !v);
    endtask
    task automatic ref_chk(input logic run);
        repeat (6) begin
            @(negedge clk);
            chk(s_out, run ? ref_prev : 1'b0);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial begin
        n_fail = 0;
        check_count = 0;
        {rst, pg, lock, s_val, en_n} = {4'b1001, 6'h00};
        {awaddr, wdata, araddr} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        sp_lvl = 2'h1;
        wait_clk(4);
        rst <= 1'b0;
        wait_clk(4);
        chk(s_oe, 1'b0);
        pg <= 1'b1;
        wait_clk(3);
        s_val <= 1'b0;
        @(negedge clk);
        chk(b_addr, BUS_ADDR_STRAP_HIGH);
        chk(sp_sel, SPREAD_QUARTER);
        chk(s_oe, 1'b1);
        ref_chk(1'b1);
        park_chk(6'h3F, 2'h0);
        wait_clk(1);
        lock <= 1'b1;
        wait_clk(4);
        for (int i = 0; i < 6; i++) run_chk(i);
        rd_reg(STATUS_OFFSET);
        chk(rd, 32'h003F316A);
        rd_reg(CTRL_OFFSET);
        chk(rd, 32'h0000013F);
        en_n <= 6'h01;
        wait_clk(3);
        park_chk(6'h01, 2'h0);
        run_chk(1);
        wr(CTRL_OFFSET, 32'h0002013D);
        wait_clk(3);
        park_chk(6'h03, 2'h2);
        run_chk(2);
        rd_reg(8'h08);
        chk(rs, RESP_SLVERR);
        chk(rd, 32'h0);
        wr(8'h0C, 32'h0);
        chk(rs, RESP_SLVERR);
        rd_reg(CTRL_OFFSET);
        chk(rd, 32'h0002013D);
        pg <= 1'b0;
        wait_clk(3);
        park_chk(6'h3F, 2'h2);
        ref_chk(1'b0);
        rd_reg(STATUS_OFFSET);
        chk(rd[STAT_PD_BIT], 1'b1);
        wr(CTRL_OFFSET, 32'h0002033D);
        wait_clk(2);
        ref_chk(1'b1);
        pg <= 1'b1;
        wait_clk(4);
        run_chk(2);
        chk(b_addr, BUS_ADDR_STRAP_HIGH);
        wr(CTRL_OFFSET, 32'h0002023D);
        wait_clk(2);
        ref_chk(1'b0);
        // Fresh power-ups with the other spread levels, address strap low
        for (int k = 0; k < 2; k++) begin
            wait_clk(1);
            {rst, pg, s_val} <= 3'b100;
            sp_lvl <= k ? 2'h0 : 2'h2;
            wait_clk(4);
            rst <= 1'b0;
            wait_clk(2);
            @(negedge clk);
            chk(s_oe, 1'b0);
            chk({t, c}, 12'h000);
            wait_clk(1);
            pg <= 1'b1;
            wait_clk(3);
            @(negedge clk);
            chk(b_addr, BUS_ADDR_STRAP_LOW);
            chk(sp_sel, k ? SPREAD_OFF : SPREAD_HALF);
        end
        rd_reg(CTRL_OFFSET);
        chk(rd, 32'h0000013F);
        chk(rs, RESP_OKAY);
        close_out();
    end
endmodule
`default_nettype wire
